// ---- include/video_out_pkg.sv ----
// constants shared by the video output stage
package video_out_pkg;
	localparam int TIME_W   = 12;
	localparam int PIX_W    = 10;
	// signed coefficient, 1024 is unity, reaches about +12 dB
	// gain headroom sizing
	localparam int COEF_BITS = 13;
	localparam int NUM_COEF  = 9;
	localparam int MAT_SHIFT = 10;
	localparam int TRS_LEN   = 4;
	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_HACT   = 8'h04;
	localparam logic [7:0] REG_HLEN   = 8'h08;
	localparam logic [7:0] REG_VACT   = 8'h0C;
	localparam logic [7:0] REG_VLEN   = 8'h10;
	localparam logic [7:0] REG_ADJ    = 8'h14;
	localparam logic [7:0] REG_BG     = 8'h18;
	localparam logic [7:0] REG_COEF0  = 8'h1C;
	localparam logic [7:0] REG_STATUS = 8'h40;
	// field positions
	localparam int F_MODE = 0;
	localparam int F_TRS  = 2;
	localparam int F_REF  = 3;
	localparam int F_W10  = 4;
	localparam int F_LO   = 0;
	localparam int F_HI   = 16;
	localparam int F_BGY  = 0;
	localparam int F_BGCB = 10;
	localparam int F_BGCR = 20;
	localparam int F_LOCK = 28;
	localparam int F_CERR = 29;
	// reset values
	localparam logic [1:0]  RST_MODE        = 2'h1;
	localparam logic        RST_TRS         = 1'b1;
	localparam logic        RST_REF         = 1'b0;
	localparam logic        RST_W10         = 1'b1;
	localparam logic [11:0] RST_LINE_LEN    = 12'h2D0;
	localparam logic [11:0] RST_TOTAL_LEN   = 12'h35A;
	localparam logic [11:0] RST_V_START     = 12'h014;
	localparam logic [11:0] RST_V_STOP      = 12'h1F4;
	localparam logic [11:0] RST_TOTAL_LINES = 12'h20D;
	localparam logic [12:0] RST_UNITY       = 13'h0400;
	// video levels
	localparam logic [9:0] MAT_Y_OFS = 10'h040;
	localparam logic [9:0] OFS_GBR   = 10'h200;
	localparam logic [9:0] OFS_YC    = 10'h040;
	localparam logic [9:0] BLANK_Y   = 10'h040;
	localparam logic [9:0] BLANK_C   = 10'h200;
	localparam logic [9:0] CLIP10_LO = 10'h004;
	localparam logic [9:0] CLIP10_HI = 10'h3FB;
	localparam logic [7:0] CLIP8_LO  = 8'h01;
	localparam logic [7:0] CLIP8_HI  = 8'hFE;
	localparam logic [9:0] TRS_ONE   = 10'h3FF;
	localparam logic [9:0] TRS_ZERO  = 10'h000;
endpackage

// ---- include/pix_if.sv ----
// 4:4:4 pixel carrier from the chroma stage to the matrix
`timescale 1ns/1ps
`default_nettype none
interface pix_if;
	logic [9:0]        y;
	logic signed [9:0] cb;
	logic signed [9:0] cr;
	modport src (output y, cb, cr);
	modport dst (input y, cb, cr);
endinterface
`default_nettype wire

// ---- rtl/mat_row.sv ----
// one row of the colour matrix with saturation
`timescale 1ns/1ps
`default_nettype none
module mat_row
	import video_out_pkg::*;
#(
	parameter int COEF_W = COEF_BITS
) (
	// pixel in
	input  wire logic [9:0]               y,
	input  wire logic signed [9:0]        cb,
	input  wire logic signed [9:0]        cr,
	// coefficients and offset
	input  wire logic signed [COEF_W-1:0] c1,
	input  wire logic signed [COEF_W-1:0] c2,
	input  wire logic signed [COEF_W-1:0] c3,
	input  wire logic [9:0]               offset,
	// result
	output logic [9:0]                    res
);
	localparam int S = COEF_W + 13;
	logic signed [10:0]  yo;
	logic signed [S-1:0] sum;
	logic signed [S-1:0] r;

	assign yo = $signed({1'b0, y}) - $signed({1'b0, MAT_Y_OFS});

	always_comb begin
		// three products over 1024 plus offset
		// widen before multiplying, a self-sized product would drop its top bits
		sum = S'(c1) * S'(yo) + S'(c2) * S'(cb) + S'(c3) * S'(cr);
		r   = (sum >>> MAT_SHIFT) + S'($signed({1'b0, offset}));
		if (r < 0)
			res = 10'h000;
		else if (r > S'(1023))
			res = 10'h3FF;
		else
			res = r[9:0];
	end
endmodule
`default_nettype wire

// ---- rtl/chroma_444.sv ----
// chroma upsampling, background fill and edge shaping
`timescale 1ns/1ps
`default_nettype none
module chroma_444 (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// 4:2:2 pixels, cb on even live samples
	input  wire logic [9:0]        y_in,
	input  wire logic signed [9:0] c_in,
	input  wire logic              live,
	input  wire logic              active,
	// settings
	input  wire logic [9:0]        bg_y,
	input  wire logic [9:0]        bg_cb,
	input  wire logic [9:0]        bg_cr,
	input  wire logic              shape_l,
	input  wire logic              shape_r,
	// 4:4:4 out
	pix_if.src                     pix
);
	import video_out_pkg::*;
	typedef struct packed {
		logic [9:0] s1_y, s1_cb, s1_cr, hold_cb, hold_cr, y, cb, cr;
		logic       s1_live, s1_act, s1_first, prev_live, phase;
	} ups_t;
	ups_t st, next_st;
	logic ph;

	function automatic logic [9:0] avg(input logic [9:0] a, input logic [9:0] b);
		logic [10:0] s;
		s = {a[9], a} + {b[9], b};
		return s[10:1];
	endfunction

	always_comb begin
		next_st = st;
		ph = st.prev_live ? st.phase : 1'b0;
		next_st.prev_live = live;
		next_st.s1_live = live;
		next_st.s1_act = active;
		next_st.s1_first = live & ~st.prev_live;
		next_st.s1_y = y_in;
		// each luma gets its own cb and cr
		if (live) begin
			next_st.phase = ~ph;
			if (!ph) begin
				next_st.s1_cb = c_in;
				next_st.s1_cr = st.hold_cr;
				next_st.hold_cb = c_in;
			end else begin
				next_st.s1_cb = st.hold_cb;
				next_st.s1_cr = c_in;
				next_st.hold_cr = c_in;
			end
		end
		if (!st.s1_act) begin
			next_st.y = BLANK_Y;
			next_st.cb = 10'h000;
			next_st.cr = 10'h000;
		end else if (!st.s1_live) begin
			next_st.y = bg_y;
			next_st.cb = bg_cb;
			next_st.cr = bg_cr;
		end else if ((shape_l && st.s1_first) || (shape_r && !live)) begin
			next_st.y = 10'(({1'b0, st.s1_y} + {1'b0, bg_y}) >> 1);
			next_st.cb = avg(st.s1_cb, bg_cb);
			next_st.cr = avg(st.s1_cr, bg_cr);
		end else begin
			next_st.y = st.s1_y;
			next_st.cb = st.s1_cb;
			next_st.cr = st.s1_cr;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	assign pix.y  = st.y;
	assign pix.cb = st.cb;
	assign pix.cr = st.cr;
endmodule
`default_nettype wire

// ---- rtl/video_out_stage.sv ----
// video output stage: matrix, formatter and output timing
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - upsample chroma to 4:4:4 so each luma has own Cb, Cr
// - shape left edge if start above 0, right if stop below length
// - fill non-live part of the active area with background colour before the matrix
// - luma out is three products over 1024 plus 64
// - chroma out likewise, offset 512 in mode 0, else 64
// - coefficients wide enough for about +12 dB gain
// - Cb and Cr into the matrix are two's complement
// - B, R offset binary (offset 512) in mode 0, unsigned (offset 64) in modes 1 to 3
// - all nine coefficients are software programmable
// - pack one, two or three channels by mode, insert TRS
// - with TRS on clip to 4..1019 or 1..254
// - horizontal and vertical counters bounded by format settings
// - lock to input TRS when reference 0, to pin when 1
// - line advance moves output earlier by that many lines
// - horizontal position delays output by that many samples
// - about two fields latency, set by the memory stage upstream
// - last active line after memory switch point is unsupported
module video_out_stage
	import video_out_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int CW     = TIME_W
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// scaled pixels in
	input  wire logic [9:0]        y_in,
	input  wire logic signed [9:0] c_in,
	input  wire logic              in_trs_ref,
	output logic                   pix_req,
	// external frame reference
	input  wire logic              ext_frame_reset_in,
	// formatted video out
	output logic [9:0]             gout,
	output logic [9:0]             bout,
	output logic [9:0]             rout,
	output logic                   out_de,
	output logic                   out_locked
);
	typedef struct packed {
		logic [1:0]                         out_mode;
		logic                               trs_en, out_ref, word10;
		logic [CW-1:0]                      active_h_start, active_h_stop;
		logic [CW-1:0]                      active_line_length, total_line_length;
		logic [CW-1:0]                      v_start, v_stop, total_lines, switch_line;
		logic [CW-1:0]                      line_advance, h_pos;
		logic [9:0]                         bg_y, bg_cb, bg_cr;
		logic [NUM_COEF-1:0][COEF_BITS-1:0] coef;
		logic [31:0]                        rdata;
		logic                               err;
		logic [2:0]                         sync;
		logic [CW-1:0]                      h, v, dly, h_d1, v_d1, h_d2, v_d2;
		logic                               dly_run, locked;
		logic [9:0]                         g, b, r;
		logic                               de, de_d1, de_d2;
	} top_t;

	top_t        st, next_st;
	logic [31:0] rd;
	logic        hit, wr, setup, ref_ev, act, live, cfg_err;
	logic        act_v, eav, sav, vbl, hbit;
	logic [1:0]  idx;
	logic [9:0]  mg, mb, mr, coff, xyz, trs_w, vg, vb, vr, blk_g, blk_c;

	pix_if pix ();

	function automatic top_t rst_state();
		top_t s;
		s = '0;
		s.out_mode = RST_MODE;
		s.trs_en = RST_TRS;
		s.out_ref = RST_REF;
		s.word10 = RST_W10;
		s.active_h_stop = CW'(RST_LINE_LEN);
		s.active_line_length = CW'(RST_LINE_LEN);
		s.total_line_length = CW'(RST_TOTAL_LEN);
		s.v_start = CW'(RST_V_START);
		s.v_stop = CW'(RST_V_STOP);
		s.total_lines = CW'(RST_TOTAL_LINES);
		s.switch_line = CW'(RST_TOTAL_LINES);
		s.bg_y = BLANK_Y;
		s.coef[0] = RST_UNITY;
		s.coef[4] = RST_UNITY;
		s.coef[8] = RST_UNITY;
		return s;
	endfunction

	// clip illegal codes when TRS is on
	function automatic logic [9:0] fit(input logic [9:0] w, input logic w10,
		input logic en);
		logic [7:0] b8;
		b8 = w[9:2];
		if (w10) begin
			if (en && w < CLIP10_LO)
				return CLIP10_LO;
			if (en && w > CLIP10_HI)
				return CLIP10_HI;
			return w;
		end
		if (en && b8 < CLIP8_LO)
			b8 = CLIP8_LO;
		else if (en && b8 > CLIP8_HI)
			b8 = CLIP8_HI;
		return {b8, 2'h0};
	endfunction

	// current sample position, drives the pixel request
	assign act = (st.h < st.active_line_length) && (st.v >= st.v_start)
		&& (st.v < st.v_stop);
	assign live = act && (st.h >= st.active_h_start) && (st.h < st.active_h_stop);
	assign pix_req = live;

	assign cfg_err = st.v_stop > st.switch_line;

	chroma_444 u_chroma (
		.pclk    (pclk),
		.presetn (presetn),
		.y_in    (y_in),
		.c_in    (c_in),
		.live    (live),
		.active  (act),
		.bg_y    (st.bg_y),
		.bg_cb   (st.bg_cb),
		.bg_cr   (st.bg_cr),
		// shaping only where the picture is inset
		.shape_l (st.active_h_start != '0),
		.shape_r (st.active_h_stop < st.active_line_length),
		.pix     (pix)
	);

	// chroma offset depends on output mode
	// mode 0 gives offset binary B and R
	assign coff = (st.out_mode == 2'h0) ? OFS_GBR : OFS_YC;

	mat_row u_row_g (
		.y (pix.y), .cb (pix.cb), .cr (pix.cr),
		.c1 (st.coef[0]), .c2 (st.coef[1]), .c3 (st.coef[2]),
		.offset (MAT_Y_OFS), .res (mg)
	);
	mat_row u_row_b (
		.y (pix.y), .cb (pix.cb), .cr (pix.cr),
		.c1 (st.coef[3]), .c2 (st.coef[4]), .c3 (st.coef[5]),
		.offset (coff), .res (mb)
	);
	mat_row u_row_r (
		.y (pix.y), .cb (pix.cb), .cr (pix.cr),
		.c1 (st.coef[6]), .c2 (st.coef[7]), .c3 (st.coef[8]),
		.offset (coff), .res (mr)
	);

	always_comb begin
		next_st = st;
		rd = '0;
		hit = 1'b0;
		setup = psel & ~penable;
		wr = psel & penable & pwrite;
		unique case (paddr)
			ADDR_W'(REG_CTRL): begin
				hit = 1'b1;
				rd[F_MODE +: 2] = st.out_mode;
				rd[F_TRS] = st.trs_en;
				rd[F_REF] = st.out_ref;
				rd[F_W10] = st.word10;
				if (wr) begin
					next_st.out_mode = pwdata[F_MODE +: 2];
					next_st.trs_en = pwdata[F_TRS];
					next_st.out_ref = pwdata[F_REF];
					next_st.word10 = pwdata[F_W10];
				end
			end
			ADDR_W'(REG_HACT): begin
				hit = 1'b1;
				rd[F_LO +: CW] = st.active_h_start;
				rd[F_HI +: CW] = st.active_h_stop;
				if (wr) begin
					next_st.active_h_start = pwdata[F_LO +: CW];
					next_st.active_h_stop = pwdata[F_HI +: CW];
				end
			end
			ADDR_W'(REG_HLEN): begin
				hit = 1'b1;
				rd[F_LO +: CW] = st.active_line_length;
				rd[F_HI +: CW] = st.total_line_length;
				if (wr) begin
					next_st.active_line_length = pwdata[F_LO +: CW];
					next_st.total_line_length = pwdata[F_HI +: CW];
				end
			end
			ADDR_W'(REG_VACT): begin
				hit = 1'b1;
				rd[F_LO +: CW] = st.v_start;
				rd[F_HI +: CW] = st.v_stop;
				if (wr) begin
					next_st.v_start = pwdata[F_LO +: CW];
					next_st.v_stop = pwdata[F_HI +: CW];
				end
			end
			ADDR_W'(REG_VLEN): begin
				hit = 1'b1;
				rd[F_LO +: CW] = st.total_lines;
				rd[F_HI +: CW] = st.switch_line;
				if (wr) begin
					next_st.total_lines = pwdata[F_LO +: CW];
					next_st.switch_line = pwdata[F_HI +: CW];
				end
			end
			ADDR_W'(REG_ADJ): begin
				hit = 1'b1;
				rd[F_LO +: CW] = st.line_advance;
				rd[F_HI +: CW] = st.h_pos;
				if (wr) begin
					next_st.line_advance = pwdata[F_LO +: CW];
					next_st.h_pos = pwdata[F_HI +: CW];
				end
			end
			ADDR_W'(REG_BG): begin
				hit = 1'b1;
				rd[F_BGY +: 10] = st.bg_y;
				rd[F_BGCB +: 10] = st.bg_cb;
				rd[F_BGCR +: 10] = st.bg_cr;
				if (wr) begin
					next_st.bg_y = pwdata[F_BGY +: 10];
					next_st.bg_cb = pwdata[F_BGCB +: 10];
					next_st.bg_cr = pwdata[F_BGCR +: 10];
				end
			end
			ADDR_W'(REG_STATUS): begin
				hit = 1'b1;
				rd[F_LO +: CW] = st.h;
				rd[F_HI +: CW] = st.v;
				rd[F_LOCK] = st.locked;
				rd[F_CERR] = cfg_err;
			end
			default: ;
		endcase
		for (int i = 0; i < NUM_COEF; i++) begin
			if (paddr == ADDR_W'(REG_COEF0 + 8'(4 * i))) begin
				hit = 1'b1;
				rd[COEF_BITS-1:0] = st.coef[i];
				if (wr)
					next_st.coef[i] = pwdata[COEF_BITS-1:0];
			end
		end
		if (setup) begin
			next_st.rdata = pwrite ? 32'h0000_0000 : rd;
			next_st.err = ~hit;
		end

		// reference choice, pin edge after two flops
		next_st.sync = {st.sync[1:0], ext_frame_reset_in};
		ref_ev = st.out_ref ? (st.sync[1] & ~st.sync[2]) : in_trs_ref;
		if (st.h >= st.total_line_length - 1'b1) begin
			next_st.h = '0;
			next_st.v = (st.v >= st.total_lines - 1'b1) ? '0 : st.v + 1'b1;
		end else begin
			next_st.h = st.h + 1'b1;
		end
		// hold off line start by h_pos samples
		if (ref_ev) begin
			next_st.dly = st.h_pos;
			next_st.dly_run = 1'b1;
		end else if (st.dly_run) begin
			if (st.dly == '0) begin
				next_st.dly_run = 1'b0;
				// start at line_advance to run early
				next_st.h = '0;
				next_st.v = st.line_advance;
				// frame placement only; field store lies upstream
				next_st.locked = 1'b1;
			end else begin
				next_st.dly = st.dly - 1'b1;
			end
		end

		// position pipeline matches the two chroma stages
		next_st.h_d1 = st.h;
		next_st.v_d1 = st.v;
		next_st.h_d2 = st.h_d1;
		next_st.v_d2 = st.v_d1;
		next_st.de_d1 = act;
		next_st.de_d2 = st.de_d1;

		// timing reference words and channel packing
		act_v = (st.v_d2 >= st.v_start) && (st.v_d2 < st.v_stop);
		vbl = ~act_v;
		eav = (st.h_d2 >= st.active_line_length)
			&& (st.h_d2 < st.active_line_length + CW'(TRS_LEN));
		// bounded above so a shortened line never leaves a cut preamble
		sav = (st.h_d2 >= st.total_line_length - CW'(TRS_LEN))
			&& (st.h_d2 < st.total_line_length);
		hbit = eav;
		idx = eav ? 2'(st.h_d2 - st.active_line_length)
			: 2'(st.h_d2 - (st.total_line_length - CW'(TRS_LEN)));
		// single field raster, F stays low
		xyz = {1'b1, 1'b0, vbl, hbit, vbl ^ hbit, hbit, vbl, vbl ^ hbit, 2'h0};
		unique case (idx)
			2'h0: trs_w = TRS_ONE;
			2'h1, 2'h2: trs_w = TRS_ZERO;
			2'h3: trs_w = xyz;
		endcase
		blk_c = (st.out_mode == 2'h0) ? BLANK_Y : BLANK_C;
		blk_g = (st.out_mode == 2'h3 && !st.h_d2[0]) ? BLANK_C : BLANK_Y;
		unique case (st.out_mode)
			2'h0, 2'h1: begin
				vg = mg;
				vb = mb;
				vr = mr;
			end
			2'h2: begin
				vg = mg;
				vb = st.h_d2[0] ? mr : mb;
				vr = BLANK_C;
			end
			2'h3: begin
				vg = st.h_d2[0] ? mg : (st.h_d2[1] ? mr : mb);
				vb = BLANK_C;
				vr = BLANK_C;
			end
		endcase
		if (st.trs_en && (eav || sav)) begin
			next_st.g = st.word10 ? trs_w : {trs_w[9:2], 2'h0};
			next_st.b = next_st.g;
			next_st.r = next_st.g;
		end else if (st.de_d2) begin
			next_st.g = fit(vg, st.word10, st.trs_en);
			next_st.b = fit(vb, st.word10, st.trs_en);
			next_st.r = fit(vr, st.word10, st.trs_en);
		end else begin
			next_st.g = fit(blk_g, st.word10, st.trs_en);
			next_st.b = fit(blk_c, st.word10, st.trs_en);
			next_st.r = fit(blk_c, st.word10, st.trs_en);
		end
		next_st.de = st.de_d2;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			st <= rst_state();
		else
			st <= next_st;
	end

	// zero wait state slave
	assign pready = 1'b1;
	assign prdata = st.rdata;
	assign pslverr = st.err & psel & penable;
	assign gout = st.g;
	assign bout = st.b;
	assign rout = st.r;
	assign out_de = st.de;
	assign out_locked = st.locked;
endmodule
`default_nettype wire

// ---- bench/video_out_stage_chk.sv ----
// port assertions for the video output stage
`timescale 1ns/1ps
`default_nettype none
module video_out_stage_chk
	import video_out_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int CW     = TIME_W
) (
	// clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// apb
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr,
	// video
	input  wire logic              pix_req,
	input  wire logic [9:0]        gout,
	input  wire logic              out_de,
	input  wire logic              out_locked
);
	default clocking dflt @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic acc;
	logic bad;
	assign acc = psel && penable;
	assign bad = (paddr > ADDR_W'(REG_STATUS)) || (paddr[1:0] != 2'h0);

	zero_wait_a: assert property (acc |-> pready)
		else $error("access phase without ready");
	map_err_a: assert property (acc && bad |-> pslverr)
		else $error("unmapped access without error");
	map_ok_a: assert property (!(acc && bad) |-> !pslverr)
		else $error("error flag on a mapped access");
	write_rdata_a: assert property (acc && pwrite |-> prdata == 32'h0)
		else $error("read data not zero on a write");
	lock_hold_a: assert property (out_locked |=> out_locked)
		else $error("lock indication dropped");
	pix_latency_a: assert property (pix_req |-> ##3 out_de)
		else $error("live sample not shown as active three cycles on");
	trs_preamble_a: assert property (!out_de && gout == 10'h3FF |=> gout == 10'h000 ##1 gout == 10'h000)
		else $error("timing preamble broken");
	trs_word_a: assert property (!out_de && gout == 10'h3FF ##1 gout == 10'h000 ##1 gout == 10'h000
		|=> gout[9] && !gout[8] && gout[5] == (gout[7] ^ gout[6]) && gout[4] == gout[6]
		&& gout[3] == gout[7] && gout[2] == gout[5] && gout[1:0] == 2'h0)
		else $error("timing word protection bits wrong");
endmodule
`default_nettype wire

// ---- bench/video_sink.sv ----
// downstream receiver that counts timing preambles outside active video
`timescale 1ns/1ps
`default_nettype none
module video_sink (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// received video
	input  wire logic [9:0] gout,
	input  wire logic       out_de,
	// preambles seen
	output var int          trs_count
);
	logic hit1;
	logic hit2;
	// upper eight bits only, so 8-bit words are seen too
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hit1 <= 1'b0;
			hit2 <= 1'b0;
			trs_count <= 0;
		end else begin
			hit1 <= !out_de && gout[9:2] == 8'hFF;
			hit2 <= hit1 && gout[9:2] == 8'h00;
			if (hit2 && gout[9:2] == 8'h00)
				trs_count <= trs_count + 1;
		end
	end
endmodule
`default_nettype wire

// ---- bench/video_out_matrix_timing_test.sv ----
// self-checking bench for the video output stage
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
	$display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module video_output_matrix_timing_test;
	import video_out_pkg::*;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [9:0]        y_in = 10'h040;
	logic signed [9:0] c_in = 10'sh000;
	logic              in_trs_ref = 1'b0;
	logic              pix_req;
	logic              ext_frame_reset_in = 1'b0;
	logic [9:0]        gout;
	logic [9:0]        bout;
	logic [9:0]        rout;
	logic              out_de;
	logic              out_locked;
	int                miscompares = 0;
	int                checks_done = 0;
	int                trs_count;
	logic [31:0]       lfsr = 32'hE762;
	logic [31:0]       rdata;
	logic              rerr;
	int                coef [9];
	int                mode = 1;
	logic              trs = 1'b1;
	logic              w10 = 1'b1;
	logic              cmp_on = 1'b0;
	int                run = 0;
	int                last_cb = 0;
	int                last_cr = 0;
	logic [29:0]       pipe [3];
	logic [2:0]        pv = 3'h0;

	always #4 pclk = ~pclk;

	video_out_stage dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .y_in(y_in), .c_in(c_in), .in_trs_ref(in_trs_ref),
		.pix_req(pix_req), .ext_frame_reset_in(ext_frame_reset_in), .gout(gout),
		.bout(bout), .rout(rout), .out_de(out_de), .out_locked(out_locked));
	video_sink sink (.pclk(pclk), .presetn(presetn), .gout(gout), .out_de(out_de),
		.trs_count(trs_count));

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic int mat(int k, int y, int cb, int cr, int ofs);
		int s;
		s = ((coef[k] * (y - 64) + coef[k + 1] * cb + coef[k + 2] * cr) >>> 10) + ofs;
		return s < 0 ? 0 : (s > 1023 ? 1023 : s);
	endfunction
	function automatic logic [9:0] fmt(int v);
		int b;
		b = v >> 2;
		if (w10)
			return 10'(trs ? (v < 4 ? 4 : (v > 1019 ? 1019 : v)) : v);
		if (trs)
			b = b < 1 ? 1 : (b > 254 ? 254 : b);
		return 10'(b << 2);
	endfunction

	always @(posedge pclk) begin
		y_in <= 10'(rnd());
		c_in <= 10'(rnd() >> 8);
	end

	// first sample of a run is skipped: its held chroma belongs to the line before
	always @(posedge pclk) begin
		int gy, pb, pr, co;
		if (pv[2] && cmp_on) begin
			`CHECK(gout, pipe[2][29:20])
			`CHECK(bout, pipe[2][19:10])
			`CHECK(rout, pipe[2][9:0])
		end
		pipe[2] = pipe[1];
		pipe[1] = pipe[0];
		if (run % 2 == 0)
			last_cb = c_in;
		else
			last_cr = c_in;
		co = mode == 0 ? 512 : 64;
		gy = mat(0, y_in, last_cb, last_cr, 64);
		pb = mat(3, y_in, last_cb, last_cr, co);
		pr = mat(6, y_in, last_cb, last_cr, co);
		case (mode)
			0, 1: pipe[0] = {fmt(gy), fmt(pb), fmt(pr)};
			2: pipe[0] = {fmt(gy), fmt(run % 2 == 0 ? pb : pr), fmt(512)};
			default: pipe[0] = {fmt(run % 4 == 0 ? pb : (run % 4 == 2 ? pr : gy)), fmt(512), fmt(512)};
		endcase
		pv = {pv[1:0], pix_req === 1'b1 && run > 0};
		run = pix_req === 1'b1 ? run + 1 : 0;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// idle cycle after each transfer keeps psel from being driven twice per step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			miscompares++;
			summarize();
		end
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
		apb(1'b0, a, 32'h0);
		`CHECK(rdata, exp)
		`CHECK(rerr, err)
	endtask

	// reference then delay, count samples to first live sample
	task automatic align(input int la, input int hp, input logic pin);
		int n;
		int e;
		wr(REG_CTRL, {27'h0, 1'b1, pin, 3'h5});
		wr(REG_ADJ, {4'h0, 12'(hp), 4'h0, 12'(la)});
		// start the reference near line start so no timing preamble is cut
		n = 0;
		while (out_de !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 300) begin
			miscompares++;
			summarize();
		end
		if (pin)
			ext_frame_reset_in <= 1'b1;
		else
			in_trs_ref <= 1'b1;
		@(posedge pclk);
		in_trs_ref <= 1'b0;
		repeat (hp + (pin ? 3 : 1)) @(posedge pclk);
		ext_frame_reset_in <= 1'b0;
		e = ((5 - la) % 4) * 48;
		n = 0;
		@(negedge pclk);
		while (pix_req !== 1'b1 && n < 300) begin
			@(negedge pclk);
			n++;
		end
		`CHECK(n == e || (pin && n == e - 1), 1'b1)
		`CHECK(out_locked, 1'b1)
		if (n >= 300)
			summarize();
		$display("test alignment %0d %0d %0d done", la, hp, pin);
	endtask

	initial begin
		int t0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHECK(out_locked, 1'b0)
		rd(REG_CTRL, 32'h0000_0015, 1'b0);
		rd(REG_COEF0, 32'h0000_0400, 1'b0);
		rd(8'h44, 32'h0, 1'b1);
		rd(8'h06, 32'h0, 1'b1);
		$display("test registers done");
		// small raster: 32 of 48 samples, lines 1 and 2 of 4 active
		wr(REG_HACT, 32'h0020_0000);
		wr(REG_HLEN, 32'h0030_0020);
		wr(REG_VACT, 32'h0003_0001);
		wr(REG_VLEN, 32'h0004_0004);
		align(0, 0, 1'b0);
		align(3, 7, 1'b0);
		align(0, 4, 1'b1);
		for (int cfg = 0; cfg < 8; cfg++) begin
			cmp_on <= 1'b0;
			mode = cfg % 4;
			trs = cfg < 4;
			w10 = cfg != 2 && cfg != 7;
			wr(REG_CTRL, {27'h0, w10, 1'b0, trs, 2'(mode)});
			// signed gains up to about twice unity
			for (int i = 0; i < 9; i++) begin
				coef[i] = $signed(rnd()) >>> 20;
				wr(REG_COEF0 + 8'(4 * i), 32'(coef[i]) & 32'h0000_1FFF);
			end
			rd(REG_COEF0 + 8'h20, 32'(coef[8]) & 32'h0000_1FFF, 1'b0);
			t0 = trs_count;
			repeat (8) @(posedge pclk);
			cmp_on <= 1'b1;
			repeat (400) @(posedge pclk);
			cmp_on <= 1'b0;
			`CHECK(trs_count > t0, trs)
			$display("test format %0d done", cfg);
		end
		summarize();
	end
endmodule
bind video_out_stage video_out_stage_chk #(.ADDR_W(ADDR_W), .CW(CW)) chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .pix_req(pix_req), .gout(gout),
	.out_de(out_de), .out_locked(out_locked));
`default_nettype wire
